// >>> rtl/cmp_pkg.sv
package cmp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int CMP_RX_TYPE_W  = 5;
    localparam int CMP_RX_DATA_W  = 8;
    localparam int CMP_TX_KIND_W  = 3;
    localparam int CMP_TX_DATA_W  = 32;
    localparam int CMP_PARAM_DEPTH = 8;

    ////////////////////////////////////////////////////////////////////////
    // Transmit kinds
    localparam logic [2:0] CMP_KIND_LTR  = 3'h0;
    localparam logic [2:0] CMP_KIND_OBFF = 3'h1;
    localparam logic [2:0] CMP_KIND_SSPL = 3'h2;
    localparam logic [2:0] CMP_KIND_PME  = 3'h3;
    localparam logic [2:0] CMP_KIND_RSV_FIRST = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Payload field positions
    localparam int CMP_LTR_SNOOP_REQ    = 31;
    localparam int CMP_LTR_SNOOP_SC_HI  = 28;
    localparam int CMP_LTR_SNOOP_SC_LO  = 26;
    localparam int CMP_LTR_SNOOP_VAL_HI = 25;
    localparam int CMP_LTR_SNOOP_VAL_LO = 16;
    localparam int CMP_LTR_NS_REQ       = 15;
    localparam int CMP_LTR_NS_SC_HI     = 12;
    localparam int CMP_LTR_NS_SC_LO     = 10;
    localparam int CMP_LTR_NS_VAL_HI    = 9;
    localparam int CMP_LTR_NS_VAL_LO    = 0;
    localparam int CMP_OBFF_CODE_HI     = 3;
    localparam int CMP_OBFF_CODE_LO     = 0;
    localparam int CMP_SSPL_HI          = 9;
    localparam int CMP_SSPL_LO          = 0;
    localparam int CMP_PME_PF_HI        = 1;
    localparam int CMP_PME_PF_LO        = 0;
    localparam int CMP_PME_VF_HI        = 9;
    localparam int CMP_PME_VF_LO        = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] CMP_PAYLOAD_RST = 32'h0000_0000;
    localparam logic [4:0]  CMP_TYPE_RST    = 5'h00;
    localparam logic [7:0]  CMP_BYTE_RST    = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // States
    typedef enum logic [3:0] {
        CMP_RX_IDLE = 4'h1,
        CMP_RX_FILL = 4'h2,
        CMP_RX_PLAY = 4'h4,
        CMP_RX_GAP  = 4'h8
    } cmp_rx_state_t;

    typedef enum logic [2:0] {
        CMP_TX_IDLE = 3'h1,
        CMP_TX_SEND = 3'h2,
        CMP_TX_DONE = 3'h4
    } cmp_tx_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [31:0] cmp_field(input int hi, input int lo);
        cmp_field = (32'hFFFF_FFFF << lo) & (32'hFFFF_FFFF >> (31 - hi));
    endfunction

    function automatic logic cmp_kind_reserved(input logic [2:0] kind);
        cmp_kind_reserved = (kind >= CMP_KIND_RSV_FIRST);
    endfunction

    // Bits of the payload that carry meaning for a given kind
    function automatic logic [31:0] cmp_payload_mask(input logic [2:0] kind);
        case (kind)
            CMP_KIND_LTR:
                cmp_payload_mask =
                    cmp_field(CMP_LTR_SNOOP_REQ, CMP_LTR_SNOOP_REQ)
                  | cmp_field(CMP_LTR_SNOOP_SC_HI, CMP_LTR_SNOOP_SC_LO)
                  | cmp_field(CMP_LTR_SNOOP_VAL_HI, CMP_LTR_SNOOP_VAL_LO)
                  | cmp_field(CMP_LTR_NS_REQ, CMP_LTR_NS_REQ)
                  | cmp_field(CMP_LTR_NS_SC_HI, CMP_LTR_NS_SC_LO)
                  | cmp_field(CMP_LTR_NS_VAL_HI, CMP_LTR_NS_VAL_LO);
            CMP_KIND_OBFF:
                cmp_payload_mask =
                    cmp_field(CMP_OBFF_CODE_HI, CMP_OBFF_CODE_LO);
            CMP_KIND_SSPL:
                cmp_payload_mask = cmp_field(CMP_SSPL_HI, CMP_SSPL_LO);
            CMP_KIND_PME:
                cmp_payload_mask = cmp_field(CMP_PME_PF_HI, CMP_PME_PF_LO)
                                 | cmp_field(CMP_PME_VF_HI, CMP_PME_VF_LO);
            default:
                cmp_payload_mask = 32'h0000_0000;
        endcase
    endfunction

endpackage

// >>> rtl/cmp_param_mem.sv
`timescale 1ns/1ps
module cmp_param_mem
    import cmp_pkg::*;
#(
    parameter int WIDTH = CMP_RX_DATA_W,
    parameter int DEPTH = CMP_PARAM_DEPTH,
    parameter int AW    = $clog2(DEPTH)
)(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Write side
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    // Read side
    input  wire logic [AW-1:0]    rdAddr,
    output      logic [WIDTH-1:0] rdData
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdData;
    } cmp_mem_state_t;

    cmp_mem_state_t st_r;
    cmp_mem_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (wrEn)
        begin
            st_nxt.mem[wrAddr] = wrData;
        end
        // Bypass so a byte written now can be read in the same cycle
        if (wrEn && (wrAddr == rdAddr))
        begin
            st_nxt.rdData = wrData;
        end
        else
        begin
            st_nxt.rdData = st_r.mem[rdAddr];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.rdData;

endmodule // cmp_param_mem

// >>> rtl/cmp_msg_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Receive-valid stays high one or more cycles, count set by beats received, at most DEPTH.
// - Parameter bytes appear one per cycle only while receive-valid is high.
// - At least one idle cycle of receive-valid between delivered messages.
// - Receive indication only when the receive port enable attribute is set.
// - Five-bit receive kind names the message while receive-valid is high.
// - Kinds: 0 latency, 1 flush/fill, 2 slot power, 3 PME; 4 to 7 reserved.
// - Latency payload: snoop and no-snoop requirement, scale, value.
// - Flush/fill code in bits 3:0; slot power scale and value in 9:0.
// - PME payload: 1:0 physical, 9:4 virtual functions; several at once.
// - Transmit acknowledge is high for exactly one cycle after completion.
module cmp_msg_port
    import cmp_pkg::*;
#(
    parameter int DEPTH = CMP_PARAM_DEPTH
)(
    // Clock and reset
    clock,
    rst_n,
    // Configuration
    rxMsgPortEnableAttr,
    // Link receive side, one parameter byte per beat
    linkRxValid,
    linkRxReady,
    linkRxType,
    linkRxByte,
    linkRxLast,
    // User receive side
    rxMsgValid,
    rxMsgType,
    rxMsgData,
    // User transmit side
    txMsgReq,
    txMsgKind,
    txMsgPayload,
    txMsgDone,
    // Link transmit side
    linkTxValid,
    linkTxReady,
    linkTxKind,
    linkTxPayload
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    input  wire logic                     clock;
    input  wire logic                     rst_n;
    input  wire logic                     rxMsgPortEnableAttr;
    input  wire logic                     linkRxValid;
    output      logic                     linkRxReady;
    input  wire logic [CMP_RX_TYPE_W-1:0] linkRxType;
    input  wire logic [CMP_RX_DATA_W-1:0] linkRxByte;
    input  wire logic                     linkRxLast;
    output      logic                     rxMsgValid;
    output      logic [CMP_RX_TYPE_W-1:0] rxMsgType;
    output      logic [CMP_RX_DATA_W-1:0] rxMsgData;
    input  wire logic                     txMsgReq;
    input  wire logic [CMP_TX_KIND_W-1:0] txMsgKind;
    input  wire logic [CMP_TX_DATA_W-1:0] txMsgPayload;
    output      logic                     txMsgDone;
    output      logic                     linkTxValid;
    input  wire logic                     linkTxReady;
    output      logic [CMP_TX_KIND_W-1:0] linkTxKind;
    output      logic [CMP_TX_DATA_W-1:0] linkTxPayload;

    typedef struct packed {
        cmp_rx_state_t            rxState;
        logic [CW-1:0]            len;
        logic [AW-1:0]            rdIdx;
        logic [CMP_RX_TYPE_W-1:0] rxType;
        cmp_tx_state_t            txState;
        logic [CMP_TX_KIND_W-1:0] txKind;
        logic [CMP_TX_DATA_W-1:0] txPayload;
    } cmp_core_state_t;

    cmp_core_state_t st_r;
    cmp_core_state_t st_nxt;

    logic          beatTaken;
    logic [CW-1:0] cntNow;
    logic          memWrEn;
    logic          rxLastBeat;

    ////////////////////////////////////////////////////////////////////////
    // Receive path

    assign linkRxReady = (st_r.rxState == CMP_RX_IDLE)
                      || (st_r.rxState == CMP_RX_FILL);
    assign beatTaken   = linkRxValid && linkRxReady;
    assign cntNow      = (st_r.rxState == CMP_RX_IDLE) ? '0 : st_r.len;
    // Bytes beyond the buffer depth are dropped, the message still plays
    assign memWrEn     = beatTaken && (cntNow < CW'(DEPTH));
    assign rxLastBeat  = (st_r.rxState == CMP_RX_PLAY)
                      && (CW'(st_r.rdIdx) == st_r.len - CW'(1));

    assign rxMsgValid = (st_r.rxState == CMP_RX_PLAY);
    assign rxMsgType  = st_r.rxType;

    cmp_param_mem #(
        .WIDTH (CMP_RX_DATA_W),
        .DEPTH (DEPTH)
    ) u_param_mem (
        .clock  (clock),
        .rst_n  (rst_n),
        .wrEn   (memWrEn),
        .wrAddr (cntNow[AW-1:0]),
        .wrData (linkRxByte),
        .rdAddr (st_nxt.rdIdx),
        .rdData (rxMsgData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit path

    assign linkTxValid   = (st_r.txState == CMP_TX_SEND);
    assign linkTxKind    = st_r.txKind;
    assign linkTxPayload = st_r.txPayload;
    assign txMsgDone     = (st_r.txState == CMP_TX_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        case (st_r.rxState)
            CMP_RX_IDLE, CMP_RX_FILL:
            begin
                if (beatTaken)
                begin
                    if (st_r.rxState == CMP_RX_IDLE)
                    begin
                        st_nxt.rxType = linkRxType;
                    end
                    st_nxt.len = memWrEn ? cntNow + CW'(1) : cntNow;
                    st_nxt.rdIdx = '0;
                    // drop when the port is disabled
                    if (linkRxLast && rxMsgPortEnableAttr)
                    begin
                        st_nxt.rxState = CMP_RX_PLAY;
                    end
                    else if (linkRxLast)
                    begin
                        st_nxt.rxState = CMP_RX_IDLE;
                    end
                    else
                    begin
                        st_nxt.rxState = CMP_RX_FILL;
                    end
                end
            end
            CMP_RX_PLAY:
            begin
                if (rxLastBeat)
                begin
                    st_nxt.rxState = CMP_RX_GAP;
                end
                else
                begin
                    st_nxt.rdIdx = st_r.rdIdx + AW'(1);
                end
            end
            CMP_RX_GAP:
            begin
                st_nxt.rxState = CMP_RX_IDLE;
            end
            default:
            begin
                st_nxt.rxState = CMP_RX_IDLE;
            end
        endcase

        case (st_r.txState)
            CMP_TX_IDLE:
            begin
                // inputs are captured once and held for the link
                if (txMsgReq)
                begin
                    st_nxt.txKind = txMsgKind;
                    st_nxt.txPayload = txMsgPayload
                                     & cmp_payload_mask(txMsgKind);
                    // reserved kinds are answered, never sent
                    st_nxt.txState = cmp_kind_reserved(txMsgKind)
                                   ? CMP_TX_DONE : CMP_TX_SEND;
                end
            end
            CMP_TX_SEND:
            begin
                if (linkTxReady)
                begin
                    st_nxt.txState = CMP_TX_DONE;
                end
            end
            CMP_TX_DONE:
            begin
                st_nxt.txState = CMP_TX_IDLE;
            end
            default:
            begin
                st_nxt.txState = CMP_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.rxState   <= CMP_RX_IDLE;
            st_r.len       <= '0;
            st_r.rdIdx     <= '0;
            st_r.rxType    <= CMP_TYPE_RST;
            st_r.txState   <= CMP_TX_IDLE;
            st_r.txKind    <= CMP_KIND_LTR;
            st_r.txPayload <= CMP_PAYLOAD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence msgEnds;
        beatTaken && linkRxLast;
    endsequence

    sequence txSent;
        linkTxValid && linkTxReady;
    endsequence

    AST_RX_START: assert property (
        (msgEnds and rxMsgPortEnableAttr) |=> rxMsgValid)
        else $error("message not delivered after its last beat");

    AST_RX_COUNT: assert property (
        (msgEnds and rxMsgPortEnableAttr)
        |=> rxMsgValid [*1] ##0 (st_r.len >= CW'(1)))
        else $error("delivered message has no beat");

    AST_RX_DATA_FIRST: assert property (
        (msgEnds and rxMsgPortEnableAttr and (st_r.rxState == CMP_RX_IDLE))
        |=> rxMsgData == $past(linkRxByte))
        else $error("single byte not presented on receive data");

    AST_RX_GAP: assert property (
        (rxMsgValid && rxLastBeat) |=> !rxMsgValid ##1 !rxMsgValid)
        else $error("no idle cycle between messages");

    // A new enabled one-beat message may follow at once and show a cycle later
    AST_RX_DISABLED: assert property (
        (msgEnds and !rxMsgPortEnableAttr and !rxMsgValid)
        |=> !rxMsgValid ##1 (!rxMsgValid
            || $past(beatTaken && linkRxLast && rxMsgPortEnableAttr)))
        else $error("indication raised while port disabled");

    AST_RX_TYPE: assert property (
        (rxMsgValid && $past(rxMsgValid)) |-> $stable(rxMsgType))
        else $error("message kind changed during delivery");

    AST_TX_ACK: assert property (
        txSent |=> txMsgDone ##1 !txMsgDone)
        else $error("acknowledge not a single cycle after send");

    AST_TX_RSV: assert property (
        (st_r.txState == CMP_TX_IDLE && txMsgReq
            && cmp_kind_reserved(txMsgKind))
        |=> txMsgDone && !linkTxValid)
        else $error("reserved kind forwarded or not answered");

    AST_TX_FIELDS: assert property (
        linkTxValid |-> (linkTxPayload & ~cmp_payload_mask(linkTxKind))
                        == 32'h0000_0000)
        else $error("undefined payload bits forwarded");

    AST_TX_HOLD: assert property (
        (linkTxValid && !linkTxReady)
        |=> linkTxValid && $stable(linkTxPayload) && $stable(linkTxKind))
        else $error("forwarded message changed before accept");

endmodule // cmp_msg_port

// >>> verif/cmp_user_model.sv
`timescale 1ns/1ps
module cmp_user_model
    import cmp_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // Command from the bench
    input  wire logic                     go,
    input  wire logic [CMP_TX_KIND_W-1:0] goKind,
    input  wire logic [CMP_TX_DATA_W-1:0] goData,
    // Core transmit side
    output      logic                     txMsgReq,
    output      logic [CMP_TX_KIND_W-1:0] txMsgKind,
    output      logic [CMP_TX_DATA_W-1:0] txMsgPayload,
    input  wire logic                     txMsgDone
);
    ////////////////////////////////////////////////////////////////
    // hold until acknowledge
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txMsgReq     <= 1'b0;
            txMsgKind    <= 3'h0;
            txMsgPayload <= 32'h0000_0000;
        end
        else if (txMsgReq && txMsgDone)
        begin
            // Released fields flip so a stale value is never trusted
            txMsgReq     <= 1'b0;
            txMsgKind    <= ~txMsgKind;
            txMsgPayload <= ~txMsgPayload;
        end
        else if (!txMsgReq && go)
        begin
            txMsgReq     <= 1'b1;
            txMsgKind    <= goKind;
            txMsgPayload <= goData;
        end
    end
endmodule // cmp_user_model

// >>> verif/cmp_msg_port_test.sv
`timescale 1ns/1ps
module cmp_msg_port_test
    import cmp_pkg::*;
;
    localparam logic [31:0] PAT = 32'hF7B3_D5E9;
    localparam logic [31:0] MASKS [8] = '{32'h9FFF_9FFF, 32'h0000_000F,
        32'h0000_03FF, 32'h0000_03F3, 32'h0, 32'h0, 32'h0, 32'h0};
    logic                     clock;
    logic                     rst_n;
    logic                     enAttr;
    logic                     linkRxValid;
    logic                     linkRxReady;
    logic [CMP_RX_TYPE_W-1:0] linkRxType;
    logic [CMP_RX_DATA_W-1:0] linkRxByte;
    logic                     linkRxLast;
    logic                     rxMsgValid;
    logic [CMP_RX_TYPE_W-1:0] rxMsgType;
    logic [CMP_RX_DATA_W-1:0] rxMsgData;
    logic                     go;
    logic [CMP_TX_KIND_W-1:0] goKind;
    logic [CMP_TX_DATA_W-1:0] goData;
    logic                     txMsgReq;
    logic [CMP_TX_KIND_W-1:0] txMsgKind;
    logic [CMP_TX_DATA_W-1:0] txMsgPayload;
    logic                     txMsgDone;
    logic                     linkTxValid;
    logic                     linkTxReady;
    logic [CMP_TX_KIND_W-1:0] linkTxKind;
    logic [CMP_TX_DATA_W-1:0] linkTxPayload;
    int                       miscompares;
    int                       checks;

    cmp_msg_port #(.DEPTH(8)) u_dut (.clock(clock), .rst_n(rst_n),
        .rxMsgPortEnableAttr(enAttr), .linkRxValid(linkRxValid),
        .linkRxReady(linkRxReady), .linkRxType(linkRxType),
        .linkRxByte(linkRxByte), .linkRxLast(linkRxLast),
        .rxMsgValid(rxMsgValid), .rxMsgType(rxMsgType),
        .rxMsgData(rxMsgData), .txMsgReq(txMsgReq), .txMsgKind(txMsgKind),
        .txMsgPayload(txMsgPayload), .txMsgDone(txMsgDone),
        .linkTxValid(linkTxValid), .linkTxReady(linkTxReady),
        .linkTxKind(linkTxKind), .linkTxPayload(linkTxPayload));

    cmp_user_model u_user (.clock(clock), .rst_n(rst_n), .go(go),
        .goKind(goKind), .goData(goData), .txMsgReq(txMsgReq),
        .txMsgKind(txMsgKind), .txMsgPayload(txMsgPayload),
        .txMsgDone(txMsgDone));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_bit(input logic got, exp, input string what);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic check_vec(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_up(input string what);
        miscompares++;
        $display("ERROR t=%0t timeout: %s", $time, what);
        report_and_stop();
    endtask

    // Offers beats at the falling edge; held until ready is seen high
    task automatic send_msg(input logic [4:0] typ, input int n,
                            input logic en);
        int k;
        for (int i = 0; i < n; i++)
        begin
            linkRxValid = 1'b1;
            linkRxType  = typ;
            linkRxByte  = 8'hA0 + 8'(i);
            linkRxLast  = (i == n - 1);
            enAttr      = en;
            for (k = 0; k < 20 && linkRxReady !== 1'b1; k++)
                @(negedge clock);
            if (k == 20)
                give_up("link ready");
            @(negedge clock);
        end
        linkRxValid = 1'b0;
        linkRxLast  = 1'b0;
        linkRxByte  = ~linkRxByte;
        linkRxType  = ~linkRxType;
    endtask

    task automatic expect_msg(input logic [4:0] typ, input int n);
        int k;
        // A long message is only shown after all its beats are taken
        for (k = 0; k < 40 && rxMsgValid !== 1'b1; k++)
            @(negedge clock);
        if (k == 40)
            give_up("receive valid");
        for (int i = 0; i < n; i++)
        begin
            check_bit(rxMsgValid, 1'b1, "rx valid");
            check_vec(32'(rxMsgType), 32'(typ), "rx type");
            check_vec(32'(rxMsgData), 32'(8'hA0 + 8'(i)), "rx byte");
            @(negedge clock);
        end
        check_bit(rxMsgValid, 1'b0, "rx gap");
    endtask

    ////////////////////////////////////////////////////////////////
    // Second message waits behind the first; the last one overflows
    task automatic test_rx_back_to_back;
        fork
            begin
                send_msg(5'h13, 2, 1'b1);
                // Let the release stand one cycle before the next offer
                @(negedge clock);
                send_msg(5'h1F, 10, 1'b1);
            end
            begin
                expect_msg(5'h13, 2);
                expect_msg(5'h1F, 8);
            end
        join
        $display("test rx_back_to_back finished");
    endtask

    task automatic test_rx_disabled;
        logic seen;
        seen = 1'b0;
        send_msg(5'h0A, 3, 1'b0);
        repeat (10)
        begin
            seen |= (rxMsgValid !== 1'b0);
            @(negedge clock);
        end
        check_bit(seen, 1'b0, "rx while disabled");
        send_msg(5'h00, 1, 1'b1);
        expect_msg(5'h00, 1);
        $display("test rx_disabled finished");
    endtask

    // Far side stalls for a number of cycles before accepting
    task automatic tx_run(input logic [2:0] kind, input int stall);
        int nFwd;
        int nDone;
        goKind = kind;
        goData = PAT;
        go     = 1'b1;
        @(negedge clock);
        go    = 1'b0;
        nFwd  = 0;
        nDone = 0;
        for (int k = 0; k < 16; k++)
        begin
            if (linkTxValid === 1'b1)
            begin
                check_vec(32'(linkTxKind), 32'(kind), "tx kind");
                check_vec(linkTxPayload, PAT & MASKS[kind],
                          "tx data");
                nFwd++;
            end
            linkTxReady = (linkTxValid === 1'b1) && (nFwd > stall);
            nDone += int'(txMsgDone === 1'b1);
            @(negedge clock);
        end
        check_vec(32'(nDone), 32'h1, "done pulses");
        check_vec(32'(nFwd), kind[2] ? 32'h0 : 32'(stall + 1), "fwd");
        check_bit(txMsgReq, 1'b0, "request dropped");
    endtask

    task automatic test_tx_kinds;
        for (int k = 0; k < 8; k++)
            tx_run(3'(k), k % 4);
        $display("test tx_kinds finished");
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        miscompares = 0;
        checks      = 0;
        rst_n       = 1'b0;
        enAttr      = 1'b0;
        linkRxValid = 1'b0;
        linkRxType  = 5'h00;
        linkRxByte  = 8'h00;
        linkRxLast  = 1'b0;
        go          = 1'b0;
        goKind      = 3'h0;
        goData      = 32'h0000_0000;
        linkTxReady = 1'b0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        check_bit(linkRxReady, 1'b1, "ready after reset");
        check_bit(rxMsgValid | txMsgDone | linkTxValid, 1'b0, "idle");
        $display("test reset finished");
        test_rx_back_to_back();
        test_rx_disabled();
        test_tx_kinds();
        report_and_stop();
    end
endmodule // cmp_msg_port_test
